/* File: common/sfp_pkg.sv */
// Notes on behaviour
// - Accept one to 128 data bytes into page buffer while select stays low.
// - Buffer byte pointer wraps from last page byte back to first.
// - Select rising after page program starts programming with no more input.
// - Programming stays busy for about five milliseconds.
// - Status and identification reads still answered while programming.
// - Standby whenever select is high and nothing is in progress.
// - Power-up gives standby with status at its initial value.
// - Completion indicator, status bit 7, starts at one.
// - Erase failure flag, status bit 4, starts at zero.
// - Program failure flag, status bit 3, starts at zero.
// - Ready flag, status bit 0, starts at one.
// - Status bits 6, 5, 2 and 1 are reserved and read zero.
// - Output data shifts out on serial clock rising edges.
// - Input bits are captured on serial clock rising edges.
// - Every byte travels most significant bit first.
// - Byte-address byte: don't-care top bit, then A6..A0.
// - First address byte: four don't-care bits, then A20..A17.
// - Second address byte holds A16..A9.
// - Third address byte: six don't-care bits, then A8 and A7.
// - Page program is opcode f2, three address bytes, byte address, data.
// - Failure flag set refuses new program or erase until clear status.
// - Bit 7 falls on completion, rises on program, erase or clear status; erase opcodes are ignored here, so only program and clear status raise it.
// - Unknown opcode: standby, output off, ignore until next select fall; standby_o rises here only while no program is running.
package sfp_pkg;

  // Command opcodes
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'hf2;
  localparam logic [7:0] OP_STATUS_READ  = 8'h83;
  localparam logic [7:0] OP_CLEAR_STATUS = 8'h89;
  localparam logic [7:0] OP_ID_READ      = 8'h85;
  localparam logic [7:0] OP_READ_ARRAY   = 8'h52;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hf1;
  localparam logic [7:0] OP_CHIP_ERASE   = 8'hf4;

  // Identification bytes, values arbitrary
  localparam logic [7:0] ID_MANUFACTURER = 8'h5a;
  localparam logic [7:0] ID_DEVICE       = 8'h3c;

  // Status register layout and power-up value
  localparam int         ST_COMPLETE_BIT  = 7;
  localparam int         ST_ERASE_ERR_BIT = 4;
  localparam int         ST_PROG_ERR_BIT  = 3;
  localparam int         ST_READY_BIT     = 0;
  localparam logic [7:0] ST_RESERVED_MASK = 8'h66;
  localparam logic [7:0] STATUS_RESET     = 8'h81;

  // Page geometry
  localparam logic [7:0] PAGE_BYTES     = 8'h80;
  localparam logic [6:0] PAGE_LAST      = 7'h7f;
  localparam int         PAGE_NUM_W     = 14;
  localparam int         FLASH_ADDR_W   = 21;
  localparam logic [1:0] HDR_FIRST      = 2'h0;
  localparam logic [1:0] HDR_SECOND     = 2'h1;
  localparam logic [1:0] HDR_THIRD      = 2'h2;

  // Programming time
  localparam int CLOCK_HZ     = 10_000_000;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES  = PROG_TIME_MS * (CLOCK_HZ / 1000);
  localparam int TIMER_W      = 17;

  // Word buffer toward the array
  localparam int BUF_DEPTH = 2;
  localparam int PROG_WORD_W = FLASH_ADDR_W + 8;

endpackage

/* File: rtl/sfp_buf.sv */
// Two-entry word buffer with valid/ready on both sides
module sfp_buf #(
  parameter int WIDTH = sfp_pkg::PROG_WORD_W,
  parameter int DEPTH = sfp_pkg::BUF_DEPTH
) (
  // Clock, reset and enable
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  // Filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  // Depth must be a power of two so pointers wrap by overflow
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 count;
  } sfp_buf_state_type;

  sfp_buf_state_type s;
  sfp_buf_state_type next_s;
  logic              push;
  logic              pop;

  // Honest full and empty from the occupancy count
  assign in_ready_o  = (s.count != (AW+1)'(DEPTH));
  assign out_valid_o = (s.count != '0);
  assign out_data_o  = s.mem[s.rd];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer and count update
  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wr] = in_data_i;
      next_s.wr        = s.wr + AW'(1);
    end
    if (pop)
      next_s.rd = s.rd + AW'(1);
    if (push && !pop)
      next_s.count = s.count + {{AW{1'h0}}, 1'h1};
    else if (pop && !push)
      next_s.count = s.count - {{AW{1'h0}}, 1'h1};
  end

  // State register
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      s <= '0;
    else if (ce_i)
      s <= next_s;
  end

endmodule // sfp_buf

/* File: rtl/sfp_page_program.sv */
// Serial flash slave: command framing, page buffer, program sequencing
module sfp_page_program #(
  parameter int PROG_CYCLES = sfp_pkg::PROG_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  // Serial pins
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        si_i,
  output logic             so_o,
  output logic             so_oe_o,
  // Array program port
  output logic             prog_valid_o,
  input  wire logic        prog_ready_i,
  output logic [20:0]      prog_addr_o,
  output logic [7:0]       prog_data_o,
  input  wire logic        prog_fail_i,
  // Observation
  output logic [7:0]       flash_operation_state_o,
  output logic             standby_o
);

  typedef enum logic [3:0] {
    FR_IDLE,
    FR_OPCODE,
    FR_ADDR,
    FR_DATA,
    FR_STATUS,
    FR_ID_DUMMY,
    FR_ID_OUT,
    FR_IGNORE,
    FR_REJECT
  } sfp_frame_type;

  typedef enum logic [1:0] {
    PG_IDLE,
    PG_STREAM,
    PG_WAIT
  } sfp_prog_type;

  typedef struct packed {
    logic                           cs_m;
    logic                           cs_s;
    logic                           cs_d;
    logic                           ck_m;
    logic                           ck_s;
    logic                           ck_d;
    logic                           si_m;
    logic                           si_s;
    sfp_frame_type                  frame;
    logic [2:0]                     bit_cnt;
    logic [1:0]                     hdr_cnt;
    logic [6:0]                     shreg;
    logic [7:0]                     osh;
    logic                           so;
    logic                           so_oe;
    logic                           id_sel;
    logic [sfp_pkg::PAGE_NUM_W-1:0] page;
    logic [6:0]                     ptr;
    logic [7:0]                     load_cnt;
    logic [127:0]                   mask;
    logic [127:0][7:0]              pbuf;
    sfp_prog_type                   prog;
    logic [6:0]                     idx;
    logic [sfp_pkg::TIMER_W-1:0]    timer;
    logic                           pend_fail;
    logic                           complete;
    logic                           erase_err;
    logic                           prog_err;
    logic                           ready;
  } sfp_state_type;

  sfp_state_type s;
  sfp_state_type next_s;

  logic       sclk_rise;
  logic       cs_rise;
  logic       cs_fall;
  logic       rx_done;
  logic [7:0] rx_byte;
  logic       fail_block;
  logic       start_ok;
  logic       push_valid;
  logic       push_ready;
  logic [28:0] push_data;
  logic [28:0] pop_data;

  // Status byte assembly, reserved positions forced low
  function automatic logic [7:0] status_of(input logic complete,
                                           input logic erase_err,
                                           input logic prog_err,
                                           input logic ready);
    logic [7:0] v;
    v = 8'h00;
    v[sfp_pkg::ST_COMPLETE_BIT]  = complete;
    v[sfp_pkg::ST_ERASE_ERR_BIT] = erase_err;
    v[sfp_pkg::ST_PROG_ERR_BIT]  = prog_err;
    v[sfp_pkg::ST_READY_BIT]     = ready;
    return v & ~sfp_pkg::ST_RESERVED_MASK;
  endfunction

  // Edge detection on the synchronised pins only
  assign sclk_rise  = s.ck_s & ~s.ck_d;
  assign cs_rise    = s.cs_s & ~s.cs_d;
  assign cs_fall    = ~s.cs_s & s.cs_d;
  assign rx_done    = sclk_rise & ~s.cs_s & (s.frame != FR_IDLE)
                    & (s.frame != FR_REJECT) & (s.bit_cnt == 3'h7);
  assign rx_byte    = {s.shreg, s.si_s};
  assign fail_block = s.prog_err | s.erase_err;
  // Header alone never starts a program
  assign start_ok   = cs_rise & (s.frame == FR_DATA)
                    & (s.load_cnt != 8'h00);

  // Page bytes feed the buffer in index order, unloaded bytes skipped
  assign push_valid = (s.prog == PG_STREAM) & s.mask[s.idx];
  assign push_data  = {s.page, s.idx, s.pbuf[s.idx]};

  // Outputs
  assign so_o                    = s.so;
  assign so_oe_o                 = s.so_oe;
  assign prog_addr_o             = pop_data[28:8];
  assign prog_data_o             = pop_data[7:0];
  assign flash_operation_state_o = status_of(s.complete, s.erase_err,
                                             s.prog_err, s.ready);
  // Standby also covers a rejected command while nothing runs
  assign standby_o = (s.cs_s | (s.frame == FR_REJECT))
                   & (s.prog == PG_IDLE);

  sfp_buf #(
    .WIDTH (sfp_pkg::PROG_WORD_W),
    .DEPTH (sfp_pkg::BUF_DEPTH)
  ) u_buf (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (prog_valid_o),
    .out_ready_i (prog_ready_i),
    .out_data_o  (pop_data)
  );

  // Next-state logic: serial framing first, program engine after
  always_comb
  begin
    logic [7:0] ob;
    logic       ld;
    ob     = 8'h00;
    ld     = 1'h0;
    next_s = s;
    // Two flops on every pin before use
    next_s.cs_m = cs_n_i;
    next_s.cs_s = s.cs_m;
    next_s.cs_d = s.cs_s;
    next_s.ck_m = sclk_i;
    next_s.ck_s = s.ck_m;
    next_s.ck_d = s.ck_s;
    next_s.si_m = si_i;
    next_s.si_s = s.si_m;

    if (s.cs_s)
    begin
      next_s.frame = FR_IDLE;
      next_s.so_oe = 1'h0;
    end
    else if (cs_fall)
    begin
      // Every select fall restarts framing, also after a reject
      next_s.frame   = FR_OPCODE;
      next_s.bit_cnt = 3'h0;
      next_s.hdr_cnt = 2'h0;
      next_s.so_oe   = 1'h0;
    end
    else if (sclk_rise && s.frame != FR_IDLE && s.frame != FR_REJECT)
    begin
      // Capture and launch on the same rising edge
      next_s.shreg   = {s.shreg[5:0], s.si_s};
      next_s.bit_cnt = s.bit_cnt + 3'h1;
      next_s.so      = s.osh[7];
      next_s.osh     = {s.osh[6:0], 1'h0};
      if (s.bit_cnt == 3'h7)
      begin
        case (s.frame)
          FR_OPCODE:
          begin
            case (rx_byte)
              sfp_pkg::OP_PAGE_PROGRAM:
              begin
                // Busy or failed device refuses a new program
                if (s.prog != PG_IDLE || fail_block)
                  next_s.frame = FR_IGNORE;
                else
                begin
                  next_s.frame    = FR_ADDR;
                  next_s.hdr_cnt  = 2'h0;
                  next_s.mask     = '0;
                  next_s.load_cnt = 8'h00;
                end
              end
              sfp_pkg::OP_STATUS_READ:
              begin
                next_s.frame = FR_STATUS;
                ob = flash_operation_state_o;
                ld = 1'h1;
              end
              sfp_pkg::OP_ID_READ:
                next_s.frame = FR_ID_DUMMY;
              sfp_pkg::OP_CLEAR_STATUS:
              begin
                next_s.prog_err  = 1'h0;
                next_s.erase_err = 1'h0;
                next_s.complete  = 1'h1;
                next_s.frame     = FR_IGNORE;
              end
              sfp_pkg::OP_READ_ARRAY,
              sfp_pkg::OP_SECTOR_ERASE,
              sfp_pkg::OP_CHIP_ERASE:
                next_s.frame = FR_IGNORE;
              default:
                next_s.frame = FR_REJECT;
            endcase
          end
          FR_ADDR:
          begin
            // Host supplies page then byte address
            next_s.hdr_cnt = s.hdr_cnt + 2'h1;
            case (s.hdr_cnt)
              sfp_pkg::HDR_FIRST:
                next_s.page[13:10] = rx_byte[3:0];
              sfp_pkg::HDR_SECOND:
                next_s.page[9:2] = rx_byte;
              sfp_pkg::HDR_THIRD:
                next_s.page[1:0] = rx_byte[1:0];
              default:
              begin
                next_s.ptr   = rx_byte[6:0];
                next_s.frame = FR_DATA;
              end
            endcase
          end
          FR_DATA:
          begin
            // Later bytes overwrite earlier ones at the same slot
            next_s.pbuf[s.ptr] = rx_byte;
            next_s.mask[s.ptr] = 1'h1;
            next_s.ptr         = s.ptr + 7'h01;
            if (s.load_cnt != sfp_pkg::PAGE_BYTES)
              next_s.load_cnt = s.load_cnt + 8'h01;
          end
          FR_STATUS:
          begin
            // Live status again every byte, so polling sees completion
            ob = flash_operation_state_o;
            ld = 1'h1;
          end
          FR_ID_DUMMY:
          begin
            ob = sfp_pkg::ID_MANUFACTURER;
            ld = 1'h1;
            next_s.id_sel = 1'h1;
            next_s.frame  = FR_ID_OUT;
          end
          FR_ID_OUT:
          begin
            ob = s.id_sel ? sfp_pkg::ID_DEVICE : sfp_pkg::ID_MANUFACTURER;
            ld = 1'h1;
            next_s.id_sel = ~s.id_sel;
          end
          default:
            next_s.frame = s.frame;
        endcase
      end
    end

    // Load a fresh output byte, first bit straight to the pin
    if (ld)
    begin
      next_s.so    = ob[7];
      next_s.osh   = {ob[6:0], 1'h0};
      next_s.so_oe = 1'h1;
    end

    // Program engine, runs on after select rises
    case (s.prog)
      PG_IDLE:
      begin
        if (start_ok)
        begin
          next_s.prog      = PG_STREAM;
          next_s.idx       = 7'h00;
          next_s.complete  = 1'h1;
          next_s.ready     = 1'h0;
          next_s.pend_fail = 1'h0;
        end
      end
      PG_STREAM:
      begin
        // Stalls while the buffer is full
        if (!push_valid || push_ready)
        begin
          next_s.idx = s.idx + 7'h01;
          if (s.idx == sfp_pkg::PAGE_LAST)
          begin
            next_s.prog  = PG_WAIT;
            next_s.timer = sfp_pkg::TIMER_W'(PROG_CYCLES - 1);
          end
        end
      end
      PG_WAIT:
      begin
        if (s.timer != '0)
          next_s.timer = s.timer - {{(sfp_pkg::TIMER_W-1){1'h0}}, 1'h1};
        else if (!prog_valid_o)
        begin
          // Completion beats a clear status in the same cycle
          next_s.prog     = PG_IDLE;
          next_s.ready    = 1'h1;
          next_s.complete = 1'h0;
          next_s.prog_err = next_s.prog_err | s.pend_fail;
        end
      end
      default:
        next_s.prog = PG_IDLE;
    endcase

    // Any word the array rejects fails the page
    if (prog_valid_o && prog_ready_i && prog_fail_i)
      next_s.pend_fail = 1'h1;
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      s          <= '0;
      s.cs_m     <= 1'h1;
      s.cs_s     <= 1'h1;
      s.cs_d     <= 1'h1;
      s.so       <= 1'h1;
      s.complete <= sfp_pkg::STATUS_RESET[sfp_pkg::ST_COMPLETE_BIT];
      s.ready    <= sfp_pkg::STATUS_RESET[sfp_pkg::ST_READY_BIT];
    end
    else if (ce_i)
      s <= next_s;
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_prog_start;
    ce_i && (s.prog == PG_IDLE) && start_ok;
  endsequence

  sequence s_busy_entry;
    $fell(flash_operation_state_o[sfp_pkg::ST_READY_BIT]);
  endsequence

  a_power_up_status: assert property (
    $rose(rstn_i) |-> flash_operation_state_o == sfp_pkg::STATUS_RESET
                      && standby_o)
    else $error("status not at power-up value");

  a_reserved_zero: assert property (
    (flash_operation_state_o & sfp_pkg::ST_RESERVED_MASK) == 8'h00)
    else $error("reserved status bit set");

  a_start_on_rise: assert property (
    s_prog_start |=> (s.prog == PG_STREAM)
      && !flash_operation_state_o[sfp_pkg::ST_READY_BIT]
      && flash_operation_state_o[sfp_pkg::ST_COMPLETE_BIT])
    else $error("program did not start on select rise");

  a_no_empty_start: assert property (
    ce_i && cs_rise && s.frame == FR_DATA && s.load_cnt == 8'h00
      |=> s.prog == $past(s.prog))
    else $error("program started without data");

  a_busy_hold: assert property (
    s_busy_entry |-> !flash_operation_state_o[sfp_pkg::ST_READY_BIT] [*8])
    else $error("busy ended too soon");

  a_done_marks: assert property (
    $rose(flash_operation_state_o[sfp_pkg::ST_READY_BIT])
      |-> !flash_operation_state_o[sfp_pkg::ST_COMPLETE_BIT])
    else $error("completion bit not cleared at end");

  a_refuse_fail: assert property (
    ce_i && rx_done && s.frame == FR_OPCODE
      && rx_byte == sfp_pkg::OP_PAGE_PROGRAM && fail_block
      |=> s.frame == FR_IGNORE)
    else $error("program accepted with failure flag set");

  a_reject_quiet: assert property (
    s.frame == FR_REJECT |-> !so_oe_o)
    else $error("output driven after unknown opcode");

  a_ptr_wrap: assert property (
    ce_i && rx_done && s.frame == FR_DATA && s.ptr == sfp_pkg::PAGE_LAST
      |=> s.ptr == 7'h00 && s.mask[127])
    else $error("page pointer did not wrap");

  a_status_answer: assert property (
    ce_i && rx_done && s.frame == FR_OPCODE
      && rx_byte == sfp_pkg::OP_STATUS_READ
      |=> so_oe_o && so_o == $past(flash_operation_state_o[7]))
    else $error("status read not answered");

  a_deselect_off: assert property (
    ce_i && s.cs_s |=> !so_oe_o)
    else $error("output driven while deselected");

endmodule // sfp_page_program

/* File: bench/sfp_host.sv */
// Host side of the serial link: select, link clock and data in
module sfp_host (
  // Clock
  input  wire logic clock_i,
  // Device output pin
  input  wire logic so_i,
  input  wire logic so_oe_i,
  // Host driven pins
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      si_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Deselected, link clock parked low between frames
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o   = 1'b0;
  end

  // Select, then give the sync pipeline time
  task automatic frame_begin();
    @(posedge clock_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask

  // Eight clocks per bit make the 800 ns link period
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - n; i--)
    begin
      sclk_o <= 1'b0;
      @(posedge clock_i);
      // Data changes one clock after the fall, well clear of the rise
      si_o <= tx[i];
      repeat (3) @(posedge clock_i);
      // A released pin reads as junk, never as the last bit
      rx[i] = so_oe_i ? so_i : ~so_i;
      sclk_o <= 1'b1;
      repeat (4) @(posedge clock_i);
    end
  endtask

  // Park the clock, deselect, let the device see it
  task automatic frame_end();
    sclk_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    cs_n_o <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask
endmodule // sfp_host

/* File: bench/sfp_page_program_test.sv */
// Self-checking bench for the page program slave
module sfp_page_program_test;
  timeunit 1ns;
  timeprecision 1ns;

  // Long enough that reads fit inside one busy period
  localparam int P_CYC = 500;

  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        cs_n, sclk, si, so, so_oe, standby;
  logic        prog_valid;
  logic        prog_ready = 1'b1;
  logic        prog_fail = 1'b0;
  logic        stall = 1'b0;
  logic [20:0] prog_addr;
  logic [7:0]  prog_data, status, rx;
  logic [28:0] got_q[$];
  logic [28:0] exp_q[$];
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          busy_cnt = 0;
  int          b0;
  // Opcodes that are decoded but carry no action here
  logic [7:0]  ign_ops[3] = '{sfp_pkg::OP_READ_ARRAY,
                              sfp_pkg::OP_SECTOR_ERASE,
                              sfp_pkg::OP_CHIP_ERASE};

  always #50 clock = ~clock;

  sfp_page_program #(.PROG_CYCLES(P_CYC)) DUT (
    .clock_i(clock), .rstn_i(rstn), .ce_i(1'b1),
    .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .prog_valid_o(prog_valid), .prog_ready_i(prog_ready),
    .prog_addr_o(prog_addr), .prog_data_o(prog_data),
    .prog_fail_i(prog_fail), .flash_operation_state_o(status),
    .standby_o(standby));

  sfp_host host (.clock_i(clock), .so_i(so), .so_oe_i(so_oe),
                 .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));

  // Array side: optional stalls, records every accepted word
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    prog_ready <= !stall || cycles[2];
    if (prog_valid === 1'b1 && prog_ready === 1'b1)
      got_q.push_back({prog_addr, prog_data});
    if (status[0] === 1'b0)
      busy_cnt <= busy_cnt + 1;
    if (cycles == 60000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] b);
    host.xfer(b, 8, rx);
  endtask

  task automatic rd(input logic [7:0] exp);
    host.xfer(8'ha5, 8, rx);
    chk(rx, exp);
  endtask

  // Settled sample away from the launching edge
  task automatic look(input logic [8:0] exp);
    @(negedge clock);
    chk({standby, status}, exp);
  endtask

  task automatic status_read(input logic [7:0] exp);
    host.frame_begin();
    send(sfp_pkg::OP_STATUS_READ);
    rd(exp);
    chk(standby, 1'b0);
    rd(exp);
    host.frame_end();
  endtask

  // Don't-care bits sent as ones to prove they are ignored
  task automatic page_prog(input logic [13:0] pg, input logic [6:0] ba,
                           input int n, input int tail,
                           input logic [7:0] first, input logic s,
                           input logic f);
    host.frame_begin();
    stall <= s;
    prog_fail <= f;
    send(sfp_pkg::OP_PAGE_PROGRAM);
    send({4'hf, pg[13:10]});
    send(pg[9:2]);
    send({6'h3f, pg[1:0]});
    send({1'b1, ba});
    for (int i = 0; i < n; i++)
      send(first + 8'(i));
    if (tail > 0)
      host.xfer(8'h5a, tail, rx);
    host.frame_end();
  endtask

  task automatic check_q();
    chk(got_q.size(), exp_q.size());
    foreach (exp_q[k])
      if (k < got_q.size())
        chk(got_q[k], exp_q[k]);
    got_q.delete();
    exp_q.delete();
  endtask

  task automatic wait_ready();
    for (int k = 0; k < 20000 && status[0] !== 1'b1; k++)
      @(negedge clock);
  endtask

  initial
  begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    look(9'h181);
    chk({so_oe, prog_valid}, 2'b00);
    status_read(8'h81);
    $display("Test power_up done");

    // Three bytes from the next-to-last slot wrap to slot zero
    b0 = busy_cnt;
    page_prog(14'h2a5b, 7'h7e, 3, 0, 8'h11, 1'b0, 1'b0);
    look(9'h080);
    status_read(8'h80);
    host.frame_begin();
    send(sfp_pkg::OP_ID_READ);
    send(8'h00);
    rd(sfp_pkg::ID_MANUFACTURER);
    rd(sfp_pkg::ID_DEVICE);
    host.frame_end();
    wait_ready();
    chk(busy_cnt - b0 >= P_CYC, 1'b1);
    // Scan of 128 slots plus the timer, with a little slack
    chk(busy_cnt - b0 <= P_CYC + 136, 1'b1);
    look(9'h101);
    exp_q = '{{14'h2a5b, 7'h00, 8'h13}, {14'h2a5b, 7'h7e, 8'h11},
              {14'h2a5b, 7'h7f, 8'h12}};
    check_q();
    $display("Test short_wrap done");

    // 130 bytes overwrite slots 0 and 1; array stalls and fails
    page_prog(14'h0001, 7'h00, 130, 0, 8'h00, 1'b1, 1'b1);
    wait_ready();
    look(9'h109);
    for (int i = 0; i < 128; i++)
      exp_q.push_back({14'h0001, 7'(i), 8'(i < 2 ? 128 + i : i)});
    check_q();
    $display("Test full_page done");

    // Refused while the failure flag stands
    page_prog(14'h0002, 7'h10, 2, 0, 8'h40, 1'b0, 1'b0);
    look(9'h109);
    check_q();
    // Other decoded opcodes leave the failed status alone
    foreach (ign_ops[k])
    begin
      host.frame_begin();
      send(ign_ops[k]);
      send(8'h00);
      host.frame_end();
      look(9'h109);
    end
    host.frame_begin();
    send(sfp_pkg::OP_CLEAR_STATUS);
    host.frame_end();
    look(9'h181);
    $display("Test refuse_clear done");

    // Header plus a partial byte starts nothing
    page_prog(14'h0003, 7'h20, 0, 4, 8'h00, 1'b0, 1'b0);
    look(9'h181);
    check_q();
    $display("Test partial done");

    // Unknown opcode, then a valid one in the same frame is ignored
    host.frame_begin();
    send(8'h12);
    send(sfp_pkg::OP_STATUS_READ);
    host.xfer(8'ha5, 8, rx);
    chk({so_oe, standby}, 2'b01);
    host.frame_end();
    status_read(8'h81);
    $display("Test bad_opcode done");
    wrap_up();
  end
endmodule // sfp_page_program_test
